// ---- inc/sdsp_pkg.sv ----
// Purpose: shared constants and types of the sdio card slave port
// Assumes: card bus framing as in the published sdio card protocol
// Notes:   offsets, command codes and reply constants live here; register depth and reset values sit in the port
package sdsp_pkg;
  localparam int          MCLK_MHZ         = 100;      // internal bus clock rate
  localparam int          BUS_MIN_MHZ      = 50;       // least bus clock while the port is used
  localparam int          CARD_CLK_MAX_MHZ = 50;       // fastest card clock the host may run
  localparam logic [5:0]  FRAME_LAST       = 6'h2F;    // bit count of the 48th frame bit
  localparam logic [5:0]  CMD_GO_IDLE      = 6'h00;    // reset, selects spi when chip select low
  localparam logic [5:0]  CMD_SET_RCA      = 6'h03;    // publish relative address
  localparam logic [5:0]  CMD_IO_OCR       = 6'h05;    // operating conditions query
  localparam logic [5:0]  CMD_SELECT       = 6'h07;    // select / deselect card
  localparam logic [5:0]  CMD_IO_DIRECT    = 6'h34;    // single byte register access
  localparam logic [5:0]  IDX_R4           = 6'h3F;    // index field of an ocr reply
  localparam logic [6:0]  CRC_R4           = 7'h7F;    // ocr reply carries all-ones crc
  localparam logic [23:0] OCR_VALUE        = 24'h300000; // supported voltage window
  localparam logic [15:0] RCA_VALUE        = 16'h0001; // relative address handed out
  localparam logic [16:0] CIS_BASE         = 17'h01000; // first byte of cis/csa space
  localparam logic [16:0] CIS_LAST         = 17'h17FFF; // last byte of cis/csa space
  localparam logic [4:0]  CCCR_BUS_IF      = 5'h07;    // bus width control byte
  localparam logic [1:0]  WIDTH_WIDE       = 2'h2;     // code for four data lines
  localparam logic [1:0]  RESP_GAP         = 2'h2;     // card clocks spent in ST_GAP before the reply is loaded
  localparam logic [5:0]  SPI_LEN_R1       = 6'h07;    // last bit index of an spi r1 reply
  localparam logic [5:0]  SPI_LEN_R5       = 6'h0F;    // last bit index of an spi r5 reply
  localparam logic [3:0]  DAT_ONE_LINE     = 4'h1;     // pads used in single line mode
  localparam logic [3:0]  DAT_ALL_LINES    = 4'hF;     // pads used in wide mode

  // link side sequencing
  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_WAIT_MEM, ST_GAP, ST_SEND} sdsp_state_e;
endpackage : sdsp_pkg

// ---- rtl/sdsp_crc7.sv ----
// Purpose: crc7 over a fixed span of frame bits, msb first
// Assumes: polynomial x^7 + x^3 + 1, zero seed
// Notes:   purely combinational, one copy checks commands, one seals replies
module sdsp_crc7 #(
  parameter int N = 40
) (
  input  wire logic [N-1:0] data,
  output logic      [6:0]   crc
);
  // walk the span from the first transmitted bit
  always_comb
  begin
    logic fb;
    fb  = 1'b0;
    crc = 7'h00;
    for (int i = N - 1; i >= 0; i--)
    begin
      fb  = data[i] ^ crc[6];
      crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
  end
endmodule : sdsp_crc7

// ---- rtl/sdsp_port.sv ----
// Purpose: sdio card slave port, command path and pad hand-over
// Assumes: SD_CLK is the host card clock, MCLK the internal bus clock
// Notes:   data block transfers are not carried by this port
// Operation
// R1 - spi, one line and four line modes
// R2 - card clock anywhere from zero to 50 MHz
// R3 - bus clock at least 50 MHz while used
// R4 - cis and csa reads served from internal memory
// R5 - host programs common and function registers
// R6 - cmd and clk pads assigned after reset
// R7 - data pads switched once communication seen
// R8 - flash-owned pads keep their assignment
// R9 - outputs may launch half clock early
// R10 - framing and crc follow sdio protocol
module sdsp_port #(
  parameter int CCCR_DEPTH = 32
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        CE,
  input  wire logic        SD_CLK,
  input  wire logic        SD_CMD_I,
  output logic             SD_CMD_O,
  output logic             SD_CMD_OE,
  input  wire logic [3:0]  SD_DAT_I,
  output logic      [3:0]  SD_DAT_O,
  output logic      [3:0]  SD_DAT_OE,
  input  wire logic        EARLY_LAUNCH,
  input  wire logic [3:0]  FLASH_PAD_OWN,
  output logic             PAD_CMD_SEL,
  output logic             PAD_CLK_SEL,
  output logic      [3:0]  PAD_DAT_SEL,
  output logic             MEM_REQ,
  output logic      [16:0] MEM_ADDR,
  input  wire logic [7:0]  MEM_RDATA,
  input  wire logic        MEM_ACK,
  output logic             SPI_MODE,
  output logic             BUS_WIDE
);
  localparam int AW = $clog2(CCCR_DEPTH);

  sdsp_pkg::sdsp_state_e st_q;            // link sequencer
  logic [45:0]  rx_sh_q;                  // command bits after the start bit
  logic [5:0]   rx_cnt_q;                 // bits taken in this frame
  logic [47:0]  tx_sh_q;                  // reply shifter, msb leaves first
  logic [5:0]   tx_cnt_q, tx_len_q;       // reply position and last index
  logic [39:0]  resp_q;                   // reply head: start, dir, index, argument
  logic         r4_q, spi_q, rca_set_q, sel_q, comm_q;
  logic [5:0]   slen_q;                   // spi reply last index
  logic [1:0]   gap_q;                    // turnaround counter
  logic [7:0]   cccr_q [CCCR_DEPTH];      // common and function registers
  logic         req_tgl_q, ack_l1, ack_l2, ack_l3;
  logic [16:0]  mem_addr_q;               // held stable while a fetch is open
  logic         ce_l1, ce_l2, early_l1, early_l2;
  logic         cmd_o_p, cmd_oe_p, d0_o_p, d0_oe_p;   // rising edge launch
  logic         cmd_o_n, cmd_oe_n, d0_o_n, d0_oe_n;   // falling edge launch
  // bus clock side
  logic         req_m1, req_m2, req_m3, ack_tgl_q;
  logic [7:0]   mem_data_q;               // fetched byte, stable until next toggle
  logic         comm_m1, comm_m2, wide_m1, wide_m2, spi_m1;

  // command decode, looked at only on the last frame bit
  logic [47:0]  frame_w;
  logic [6:0]   crc_rx, crc_tx;
  logic [39:0]  dec_resp;
  logic         dec_send, dec_mem, dec_r4, dec_ok, wr_hit;
  logic [5:0]   dec_slen;
  logic [16:0]  addr_w;
  logic [7:0]   rd_w, flags_w;
  logic         in_cccr, in_cis, frame_end;

  assign frame_w   = {1'b0, rx_sh_q, SD_CMD_I};
  assign frame_end = (st_q == sdsp_pkg::ST_RECV) && (rx_cnt_q == sdsp_pkg::FRAME_LAST);
  assign addr_w    = frame_w[33:17];
  assign in_cccr   = (frame_w[38:36] == 3'h0) && (addr_w < 17'(CCCR_DEPTH));
  assign in_cis    = (frame_w[38:36] == 3'h0) && (addr_w >= sdsp_pkg::CIS_BASE) && (addr_w <= sdsp_pkg::CIS_LAST);
  assign rd_w      = in_cccr ? cccr_q[addr_w[AW-1:0]] : 8'h00;
  assign flags_w   = {2'h0, sel_q ? 2'h2 : 2'h1, 2'h0, frame_w[38:36] != 3'h0, !(in_cccr || in_cis)};
  assign wr_hit    = frame_end && dec_ok && (frame_w[45:40] == sdsp_pkg::CMD_IO_DIRECT) && frame_w[39] && in_cccr;

  sdsp_crc7 #(.N(40)) u_crc_rx (.data(frame_w[47:8]), .crc(crc_rx));   // [R10]
  sdsp_crc7 #(.N(40)) u_crc_tx (.data(resp_q), .crc(crc_tx));         // [R10]

  // frame check: direction bit, end bit and crc; spi mode runs without crc
  assign dec_ok = frame_w[46] && frame_w[0] && (spi_q || (crc_rx == frame_w[7:1]));   // [R10]

  // reply selection per command
  always_comb
  begin
    dec_resp = {2'h0, frame_w[45:40], 32'h0000_0000};
    dec_send = dec_ok;
    dec_mem  = 1'b0;
    dec_r4   = 1'b0;
    dec_slen = sdsp_pkg::SPI_LEN_R1;
    case (frame_w[45:40])
      sdsp_pkg::CMD_GO_IDLE:   // only spi answers a reset, with the idle bit
      begin
        dec_send = dec_ok && !SD_DAT_I[3];
        dec_resp[7:0] = 8'h01;
      end
      sdsp_pkg::CMD_IO_OCR:    // ready, one function, no memory
      begin
        dec_resp = {2'h0, sdsp_pkg::IDX_R4, 1'b1, 3'h1, 1'b0, 3'h0, sdsp_pkg::OCR_VALUE};
        dec_r4   = 1'b1;
      end
      sdsp_pkg::CMD_SET_RCA:   dec_resp[31:16] = sdsp_pkg::RCA_VALUE;
      sdsp_pkg::CMD_SELECT:    dec_resp[31:0]  = 32'h0000_0000;
      sdsp_pkg::CMD_IO_DIRECT: // raw write echoes the new byte
      begin
        dec_resp[15:0] = {flags_w, (frame_w[39] && frame_w[35]) ? frame_w[15:8] : rd_w};
        dec_slen       = sdsp_pkg::SPI_LEN_R5;
        dec_mem        = dec_ok && in_cis && !frame_w[39];   // [R4]
      end
      default:                 dec_send = 1'b0;  // unknown command stays silent
    endcase
  end

  // clock enable and launch choice cross into the card clock
  always_ff @(posedge SD_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ce_l1    <= 1'b0;
      ce_l2    <= 1'b0;
      early_l1 <= 1'b0;
      early_l2 <= 1'b0;
      ack_l1   <= 1'b0;
      ack_l2   <= 1'b0;
    end
    else
    begin
      ce_l1    <= CE;
      ce_l2    <= ce_l1;
      early_l1 <= EARLY_LAUNCH;
      early_l2 <= early_l1;
      ack_l1   <= ack_tgl_q;
      ack_l2   <= ack_l1;
    end
  end

  // link sequencer; logic runs on the host clock at whatever rate it is given [R2]
  always_ff @(posedge SD_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_q       <= sdsp_pkg::ST_IDLE;
      rx_sh_q    <= '0;
      rx_cnt_q   <= 6'h00;
      tx_sh_q    <= '1;
      tx_cnt_q   <= 6'h00;
      tx_len_q   <= 6'h00;
      resp_q     <= '0;
      r4_q       <= 1'b0;
      slen_q     <= sdsp_pkg::SPI_LEN_R1;
      gap_q      <= 2'h0;
      spi_q      <= 1'b0;
      rca_set_q  <= 1'b0;
      sel_q      <= 1'b0;
      comm_q     <= 1'b0;
      req_tgl_q  <= 1'b0;
      mem_addr_q <= '0;
      ack_l3     <= 1'b0;
    end
    else if (ce_l2)
    begin
      ack_l3 <= ack_l2;
      case (st_q)
        sdsp_pkg::ST_IDLE:     // start bit; spi frames also need chip select low
          if (!SD_CMD_I && (!spi_q || !SD_DAT_I[3]))
          begin
            st_q     <= sdsp_pkg::ST_RECV;
            rx_cnt_q <= 6'h01;
          end
        sdsp_pkg::ST_RECV:
        begin
          rx_sh_q  <= {rx_sh_q[44:0], SD_CMD_I};
          rx_cnt_q <= rx_cnt_q + 6'h01;
          if (frame_end)
          begin
            resp_q <= dec_resp;
            r4_q   <= dec_r4;
            slen_q <= dec_slen;
            gap_q  <= 2'h0;
            st_q   <= dec_mem ? sdsp_pkg::ST_WAIT_MEM : (dec_send ? sdsp_pkg::ST_GAP : sdsp_pkg::ST_IDLE);
            if (dec_mem)
            begin
              mem_addr_q <= addr_w;
              req_tgl_q  <= !req_tgl_q;   // [R4]
            end
            if (dec_ok)
              case (frame_w[45:40])
                sdsp_pkg::CMD_GO_IDLE:   // chip select decides the mode [R1]
                begin
                  spi_q     <= !SD_DAT_I[3];
                  rca_set_q <= 1'b0;
                  sel_q     <= 1'b0;
                end
                sdsp_pkg::CMD_SET_RCA:   rca_set_q <= 1'b1;
                sdsp_pkg::CMD_SELECT:    sel_q <= (frame_w[39:24] == sdsp_pkg::RCA_VALUE);
                sdsp_pkg::CMD_IO_DIRECT: comm_q <= comm_q || rca_set_q || spi_q;   // [R7]
                default:                 sel_q <= sel_q;
              endcase
          end
        end
        sdsp_pkg::ST_WAIT_MEM: // byte arrives once the bus side toggles back
          if (ack_l2 != ack_l3)
          begin
            resp_q[7:0] <= mem_data_q;   // [R4]
            st_q        <= sdsp_pkg::ST_GAP;
          end
        sdsp_pkg::ST_GAP:
        begin
          gap_q <= gap_q + 2'h1;
          if (gap_q == sdsp_pkg::RESP_GAP - 2'h1)
          begin
            st_q     <= sdsp_pkg::ST_SEND;
            tx_cnt_q <= 6'h00;
            if (spi_q)
            begin
              tx_sh_q  <= (slen_q == sdsp_pkg::SPI_LEN_R5) ? {resp_q[15:0], 32'hFFFF_FFFF} : {resp_q[7:0], 40'hFF_FFFF_FFFF};
              tx_len_q <= slen_q;
            end
            else
            begin
              tx_sh_q  <= {resp_q, r4_q ? sdsp_pkg::CRC_R4 : crc_tx, 1'b1};   // [R10]
              tx_len_q <= sdsp_pkg::FRAME_LAST;
            end
          end
        end
        sdsp_pkg::ST_SEND:
        begin
          tx_sh_q  <= {tx_sh_q[46:0], 1'b1};
          tx_cnt_q <= tx_cnt_q + 6'h01;
          if (tx_cnt_q == tx_len_q)
            st_q <= sdsp_pkg::ST_IDLE;
        end
        default: st_q <= sdsp_pkg::ST_IDLE;
      endcase
    end
  end

  // host written registers; each byte takes its own write [R5]
  for (genvar g = 0; g < CCCR_DEPTH; g++)
  begin : g_cccr
    always_ff @(posedge SD_CLK or posedge SYS_RST)
    begin
      if (SYS_RST)
        cccr_q[g] <= 8'h00;
      else if (ce_l2 && wr_hit && (addr_w[AW-1:0] == AW'(g)))
        cccr_q[g] <= frame_w[15:8];   // [R5]
    end
  end

  // rising edge launch: sd replies on cmd, spi replies on dat0 [R1]
  always_ff @(posedge SD_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cmd_o_p  <= 1'b1;
      cmd_oe_p <= 1'b0;
      d0_o_p   <= 1'b1;
      d0_oe_p  <= 1'b0;
    end
    else if (ce_l2)
    begin
      cmd_oe_p <= (st_q == sdsp_pkg::ST_SEND) && !spi_q;
      cmd_o_p  <= (st_q == sdsp_pkg::ST_SEND) ? tx_sh_q[47] : 1'b1;
      d0_oe_p  <= (st_q == sdsp_pkg::ST_SEND) && spi_q;
      d0_o_p   <= (st_q == sdsp_pkg::ST_SEND) ? tx_sh_q[47] : 1'b1;
    end
  end

  // falling edge copy: the normal launch, half a clock after the early one
  always_ff @(negedge SD_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cmd_o_n  <= 1'b1;
      cmd_oe_n <= 1'b0;
      d0_o_n   <= 1'b1;
      d0_oe_n  <= 1'b0;
    end
    else
    begin
      cmd_o_n  <= cmd_o_p;
      cmd_oe_n <= cmd_oe_p;
      d0_o_n   <= d0_o_p;
      d0_oe_n  <= d0_oe_p;
    end
  end

  // launch select; the mux is kept so both edges stay glitch-free flops [R9]
  assign SD_CMD_O  = early_l2 ? cmd_o_p  : cmd_o_n;
  assign SD_CMD_OE = early_l2 ? cmd_oe_p : cmd_oe_n;
  assign SD_DAT_O  = {3'h7, early_l2 ? d0_o_p : d0_o_n};
  assign SD_DAT_OE = {3'h0, early_l2 ? d0_oe_p : d0_oe_n};

  // bus side: fetch handshake and status synchronisers
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      req_m1 <= 1'b0;
      req_m2 <= 1'b0;
      req_m3 <= 1'b0;
      comm_m1 <= 1'b0;
      comm_m2 <= 1'b0;
      wide_m1 <= 1'b0;
      wide_m2 <= 1'b0;
      spi_m1 <= 1'b0;
      SPI_MODE <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_ADDR <= '0;
      mem_data_q <= 8'h00;
      ack_tgl_q <= 1'b0;
    end
    else if (CE)
    begin
      req_m1  <= req_tgl_q;
      req_m2  <= req_m1;
      req_m3  <= req_m2;
      comm_m1 <= comm_q;
      comm_m2 <= comm_m1;
      wide_m1 <= (cccr_q[sdsp_pkg::CCCR_BUS_IF][1:0] == sdsp_pkg::WIDTH_WIDE);
      wide_m2 <= wide_m1;
      spi_m1  <= spi_q;
      SPI_MODE <= spi_m1;
      if (req_m2 != req_m3)
      begin
        MEM_REQ  <= 1'b1;         // address has been stable since the toggle
        MEM_ADDR <= mem_addr_q;   // [R4]
      end
      else if (MEM_REQ && MEM_ACK)
      begin
        MEM_REQ    <= 1'b0;
        mem_data_q <= MEM_RDATA;
        ack_tgl_q  <= !ack_tgl_q;
      end
    end
  end
  assign BUS_WIDE = wide_m2;

  // pad ownership: cmd and clk from reset, data once traffic is seen
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PAD_CMD_SEL <= 1'b1;   // [R6]
      PAD_CLK_SEL <= 1'b1;   // [R6]
      PAD_DAT_SEL <= 4'h0;
    end
    else if (CE)
      PAD_DAT_SEL <= comm_m2 ? ((wide_m2 ? sdsp_pkg::DAT_ALL_LINES : sdsp_pkg::DAT_ONE_LINE)
                                & ~FLASH_PAD_OWN) : 4'h0;   // [R7] [R8]
  end

  // checks
  sequence s_frame_end;
    frame_end && ce_l2 && dec_send && !dec_mem;
  endsequence
  sequence s_reply_out;
    cmd_oe_p || d0_oe_p;
  endsequence

  a_bus_clock: assert property (@(posedge MCLK) disable iff (SYS_RST) sdsp_pkg::MCLK_MHZ >= sdsp_pkg::BUS_MIN_MHZ) // [R3]
    else $error("bus clock below card clock need");
  a_pad_default: assert property (@(posedge MCLK) disable iff (SYS_RST) PAD_CMD_SEL && PAD_CLK_SEL) // [R6]
    else $error("cmd or clk pad lost its default");
  a_pad_auto: assert property (@(posedge MCLK) disable iff (SYS_RST) // [R7]
    CE && comm_m2 && !FLASH_PAD_OWN[0] |=> PAD_DAT_SEL[0])
    else $error("dat0 pad not taken after traffic");
  a_flash_keep: assert property (@(posedge MCLK) disable iff (SYS_RST) // [R8]
    $past(CE) |-> (PAD_DAT_SEL & $past(FLASH_PAD_OWN)) == 4'h0)
    else $error("flash pad taken by card port");
  a_cis_fetch: assert property (@(posedge MCLK) disable iff (SYS_RST) // [R4]
    CE && MEM_REQ && MEM_ACK |=> !MEM_REQ && (mem_data_q == $past(MEM_RDATA)))
    else $error("memory fetch not closed");
  a_spi_entry: assert property (@(posedge SD_CLK) disable iff (SYS_RST) // [R1]
    frame_end && ce_l2 && dec_ok && frame_w[45:40] == sdsp_pkg::CMD_GO_IDLE |=> spi_q == !$past(SD_DAT_I[3]))
    else $error("mode not taken from chip select");
  a_reply_time: assert property (@(posedge SD_CLK) disable iff (SYS_RST) // [R10]
    s_frame_end |-> ##[2:6] s_reply_out)
    else $error("reply not started in time");
  a_resp_start: assert property (@(posedge SD_CLK) disable iff (SYS_RST) $rose(cmd_oe_p) |-> !cmd_o_p) // [R10]
    else $error("reply start bit not zero");
  a_resp_end: assert property (@(posedge SD_CLK) disable iff (SYS_RST) $fell(cmd_oe_p) |-> $past(cmd_o_p)) // [R10]
    else $error("reply end bit not one");
  a_early_launch: assert property (@(posedge SD_CLK) disable iff (SYS_RST) // [R9]
    early_l2 && ce_l2 |=> SD_CMD_OE == ((st_q == sdsp_pkg::ST_SEND || $past(st_q) == sdsp_pkg::ST_SEND) ? cmd_oe_p : 1'b0))
    else $error("early launch not on rising edge");
endmodule : sdsp_port

// ---- verif/sdsp_host_model.sv ----
// Purpose: behavioural sd host standing on the card bus of the slave port
// Assumes: pull-ups on cmd and data lines; host changes its lines while the clock is low
// Notes:   the card clock stands still outside frames, the reply wait, the eight trailing pulses and the reset pulses
module sdsp_host_model (
  output logic            sd_clk,
  output logic            sd_cmd_i,
  output logic [3:0]      sd_dat_i,
  input  wire logic       sd_cmd_o,
  input  wire logic       sd_cmd_oe,
  input  wire logic [3:0] sd_dat_o,
  input  wire logic [3:0] sd_dat_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic cmd_drv; // host owns the cmd line
  logic cmd_val; // level the host puts on it
  logic cs_n;    // spi select, high outside spi frames

  // released lines float up to the pull-up level, never to a stale value
  assign sd_cmd_i      = cmd_drv ? cmd_val : (sd_cmd_oe ? sd_cmd_o : 1'b1);
  // dat3 carries the spi select, the rest follow the card or the pull-ups
  assign sd_dat_i = {cs_n, (sd_dat_o[2:0] & sd_dat_oe[2:0]) | ~sd_dat_oe[2:0]};

  // idle bus: clock low, lines released
  initial
  begin
    sd_clk  = 1'b0;
    cmd_drv = 1'b0;
    cmd_val = 1'b1;
    cs_n    = 1'b1;
  end

  // one card clock of 125 ns, inside the allowed range
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++)
    begin
      #62.5 sd_clk = 1'b1;
      #62.5 sd_clk = 1'b0;
    end
  endtask : pulses

  // crc7, x^7 + x^3 + 1, zero seed, msb first
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction : crc7

  // one command frame, then collect the reply; bad spoils the crc on purpose
  task automatic cmd(input bit spi, input logic [5:0] idx, input logic [31:0] arg, input bit bad,
                     input bit early, output logic [47:0] resp, output bit got);
    logic [47:0] fr;
    int          n;
    int          len;
    fr      = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
    // spi r1 is one byte and spi r5 two bytes on dat0, sd reply 48 bits
    len     = spi ? ((idx == sdsp_pkg::CMD_IO_DIRECT) ? 16 : 8) : 48;
    cs_n    = !spi;            // select low only for spi frames
    cmd_drv = 1'b1;
    for (int k = 47; k >= 0; k--)
    begin
      cmd_val = fr[k];         // msb first, stable across the rising edge
      pulses(1);
    end
    cmd_drv = 1'b0;
    resp    = 48'h0;
    n       = 0;
    // sample on the edge opposite to the launch edge, where the line is settled
    for (int k = 0; k < 200 && n < len; k++)
    begin
      #62.5 sd_clk = 1'b1;
      if (!early && (spi ? sd_dat_oe[0] : sd_cmd_oe))
      begin
        resp = {resp[46:0], spi ? sd_dat_o[0] : sd_cmd_o};
        n++;
      end
      #62.5 sd_clk = 1'b0;
      if (early && (spi ? sd_dat_oe[0] : sd_cmd_oe))
      begin
        resp = {resp[46:0], spi ? sd_dat_o[0] : sd_cmd_o};
        n++;
      end
    end
    got = (n == len);
    pulses(8);                 // next command only after the reply has ended
    cs_n = 1'b1;
  endtask : cmd
endmodule : sdsp_host_model

// ---- verif/tb.sv ----
// Purpose: self-checking bench of the sdio card slave port
// Assumes: one host model on the card bus, a stalling memory model here
// Notes:   command rows run in table order; odd cases follow by hand
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [5:0]  idx;  // command index sent
    logic [31:0] arg;  // command argument
    logic        got;  // reply expected
    logic [5:0]  ridx; // reply index field
    logic [31:0] rarg; // reply argument
    logic        carg; // argument is checked
    logic [3:0]  pads; // data pads in card mode afterwards
    logic        wide; // four-line width afterwards
  } sdsp_row_s;

  logic        MCLK, SYS_RST, CE, EARLY_LAUNCH, MEM_ACK;
  logic [3:0]  FLASH_PAD_OWN;
  logic [7:0]  MEM_RDATA;
  wire logic   SD_CLK, SD_CMD_I, SD_CMD_O, SD_CMD_OE, PAD_CMD_SEL, PAD_CLK_SEL, MEM_REQ, SPI_MODE, BUS_WIDE;
  wire logic [3:0]  SD_DAT_I, SD_DAT_O, SD_DAT_OE, PAD_DAT_SEL;
  wire logic [16:0] MEM_ADDR;
  int          num_errors = 0; // mismatches
  int          checks     = 0; // comparisons
  int          cycles     = 0; // mclk cycles run
  int          mem_reqs   = 0; // fetches answered
  logic [16:0] mem_addr_seen;  // address of the last fetch
  logic [1:0]  mem_wait;       // stall before each ack
  logic [47:0] resp;
  bit          got;

  // flash owns pad 1 so it must never be taken
  sdsp_row_s rows [8] = '{
    '{sdsp_pkg::CMD_GO_IDLE,   32'h0, 1'b0, 6'h00, 32'h0, 1'b0, 4'h0, 1'b0},
    '{sdsp_pkg::CMD_IO_OCR,    32'h0, 1'b1, sdsp_pkg::IDX_R4, 32'h90300000, 1'b1, 4'h0, 1'b0},
    '{sdsp_pkg::CMD_SET_RCA,   32'h0, 1'b1, 6'h03, 32'h00010000, 1'b1, 4'h0, 1'b0},
    '{sdsp_pkg::CMD_SELECT,    32'h00010000, 1'b1, 6'h07, 32'h0, 1'b0, 4'h0, 1'b0},
    '{sdsp_pkg::CMD_IO_DIRECT, 32'h00000E00, 1'b1, 6'h34, 32'h00002000, 1'b1, 4'h1, 1'b0},
    '{sdsp_pkg::CMD_IO_DIRECT, 32'h88000E02, 1'b1, 6'h34, 32'h00002002, 1'b1, 4'hD, 1'b1},
    '{sdsp_pkg::CMD_IO_DIRECT, 32'h00200000, 1'b1, 6'h34, 32'h000020A5, 1'b1, 4'hD, 1'b1},
    '{sdsp_pkg::CMD_IO_DIRECT, 32'h80200055, 1'b1, 6'h34, 32'h00002000, 1'b1, 4'hD, 1'b1}};

  // 100 MHz bus clock, well above the 50 MHz floor
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // hang guard, far beyond the longest run
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      num_errors++;
      conclude();
    end
  end

  // memory: stalls two cycles, data toggles when nothing is answered
  always @(posedge MCLK)
  begin
    if (MEM_REQ && !MEM_ACK)
    begin
      if (mem_wait == 2'h2)
      begin
        MEM_ACK       <= 1'b1;
        MEM_RDATA     <= MEM_ADDR[7:0] ^ 8'hA5;
        mem_addr_seen <= MEM_ADDR;
        mem_reqs      <= mem_reqs + 1;
        mem_wait      <= 2'h0;
      end
      else
        mem_wait <= mem_wait + 2'h1;
    end
    else
    begin
      MEM_ACK   <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
    end
  end

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // reset must see link edges too, so the card clock pulses inside it
  task automatic do_reset();
    @(posedge MCLK) SYS_RST <= 1'b1;
    sdsp_host_model_pulses();
    @(posedge MCLK) SYS_RST <= 1'b0;
    u_sdsp_host_model.pulses(4);
  endtask : do_reset

  task automatic sdsp_host_model_pulses();
    u_sdsp_host_model.pulses(3);
  endtask : sdsp_host_model_pulses

  sdsp_port #(.CCCR_DEPTH(32)) u_sdsp_port (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE), .SD_CLK(SD_CLK), .SD_CMD_I(SD_CMD_I), .SD_CMD_O(SD_CMD_O),
    .SD_CMD_OE(SD_CMD_OE), .SD_DAT_I(SD_DAT_I), .SD_DAT_O(SD_DAT_O), .SD_DAT_OE(SD_DAT_OE),
    .EARLY_LAUNCH(EARLY_LAUNCH), .FLASH_PAD_OWN(FLASH_PAD_OWN), .PAD_CMD_SEL(PAD_CMD_SEL),
    .PAD_CLK_SEL(PAD_CLK_SEL), .PAD_DAT_SEL(PAD_DAT_SEL), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .SPI_MODE(SPI_MODE), .BUS_WIDE(BUS_WIDE));

  sdsp_host_model u_sdsp_host_model (
    .sd_clk(SD_CLK), .sd_cmd_i(SD_CMD_I), .sd_dat_i(SD_DAT_I), .sd_cmd_o(SD_CMD_O),
    .sd_cmd_oe(SD_CMD_OE), .sd_dat_o(SD_DAT_O), .sd_dat_oe(SD_DAT_OE));

  // main sequence: table of commands, then the awkward cases
  initial
  begin
    SYS_RST       = 1'b1;
    CE            = 1'b1;
    EARLY_LAUNCH  = 1'b0;
    FLASH_PAD_OWN = 4'h2;
    MEM_ACK       = 1'b0;
    MEM_RDATA     = 8'h00;
    mem_wait      = 2'h0;
    do_reset();
    check("reset_outs", 48'({PAD_CMD_SEL, PAD_CLK_SEL, PAD_DAT_SEL, MEM_REQ, SPI_MODE, BUS_WIDE,
          SD_CMD_OE, SD_DAT_OE, SD_CMD_O, SD_DAT_O}), 48'h6001F);
    foreach (rows[i])
    begin
      u_sdsp_host_model.cmd(1'b0, rows[i].idx, rows[i].arg, 1'b0, 1'b0, resp, got);
      check("reply_seen", 48'(got), 48'(rows[i].got));
      if (rows[i].got)
      begin
        check("reply_frame", 48'({resp[47:40], resp[0]}), 48'({2'b00, rows[i].ridx, 1'b1}));
        if (rows[i].carg)
          check("reply_arg", 48'(resp[39:8]), 48'(rows[i].rarg));
        if (rows[i].ridx == sdsp_pkg::IDX_R4)
          check("ocr_crc", 48'(resp[7:1]), 48'(sdsp_pkg::CRC_R4));
        else
          check("reply_crc", 48'(resp[7:1]), 48'(u_sdsp_host_model.crc7(resp[47:8])));
      end
      check("pads_width", 48'({PAD_DAT_SEL, BUS_WIDE}), 48'({rows[i].pads, rows[i].wide}));
    end
    // one fetch only: the write to cis space was not forwarded
    check("cis_fetch", 48'({mem_reqs[3:0], mem_addr_seen}), 48'({4'h1, sdsp_pkg::CIS_BASE}));
    @(posedge MCLK) FLASH_PAD_OWN <= 4'h0;
    repeat (10) @(posedge MCLK);
    #1 check("pads_free", 48'(PAD_DAT_SEL), 48'hF);
    u_sdsp_host_model.cmd(1'b0, sdsp_pkg::CMD_IO_OCR, 32'h0, 1'b1, 1'b0, resp, got);
    check("bad_crc", 48'(got), 48'h0);
    @(posedge MCLK) EARLY_LAUNCH <= 1'b1;
    repeat (10) @(posedge MCLK);
    u_sdsp_host_model.cmd(1'b0, sdsp_pkg::CMD_IO_OCR, 32'h0, 1'b0, 1'b1, resp, got);
    check("early_reply", resp, {2'b00, sdsp_pkg::IDX_R4, 32'h90300000, sdsp_pkg::CRC_R4, 1'b1});
    // second reset in mid-run, then spi entry with select low
    do_reset();
    u_sdsp_host_model.cmd(1'b1, sdsp_pkg::CMD_GO_IDLE, 32'h0, 1'b0, 1'b1, resp, got);
    check("spi_r1", 48'({got, resp[7:0]}), 48'h101);
    repeat (5) @(posedge MCLK);
    #1 check("spi_mode", 48'(SPI_MODE), 48'h1);
    // spi register read: flags byte (idle state) then the cleared width byte
    u_sdsp_host_model.cmd(1'b1, sdsp_pkg::CMD_IO_DIRECT, 32'h00000E00, 1'b0, 1'b1, resp, got);
    check("spi_r5", 48'({got, resp[15:0]}), 48'h11000);
    check("spi_pads", 48'({PAD_DAT_SEL, BUS_WIDE}), 48'h2);
    conclude();
  end
endmodule : tb
